// ==== verilog/sample_buffer_pkg.sv ====
// package for the acceleration sample buffer control block
// assumes one 125 MHz system clock and an 8-bit register port
package sample_buffer_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CFG_ADDR = 8'h26;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int READ_ORDER_BIT = 7;
  localparam int MODE_LSB = 5;
  localparam int GATE_BIT = 4;
  localparam int TRIG_WT_BIT = 3;
  localparam int TRIG_OT_BIT = 2;
  localparam int TRIG_OR_BIT = 0;

  // ****************************************
  // sizes
  // ****************************************
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int SAMPLE_W = 36;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CNT_W-1:0] FULL_COUNT = 6'h20;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_STREAM = 2'b01,
    MODE_STOP = 2'b10,
    MODE_TRIGGER = 2'b11
  } buf_mode_t;

  typedef struct packed {
    logic read_order;
    buf_mode_t mode;
    logic gate;
    logic trig_within_window_en;
    logic trig_outside_window_en;
    logic spare;
    logic trig_orientation_en;
  } cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } reg_req_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic valid;
  } sample_out_t;

  typedef struct packed {
    logic active;
    logic second_pin_function;
    logic sleeping;
    logic [7:0] sleep_delay_count;
    logic external_trigger_mode;
  } power_t;

endpackage

// ==== verilog/accel_sample_buffer_control.sv ====
// sample fifo and buffer control for the acceleration sample buffer
// assumes samples, triggers and power state are synchronous to clk_sys
`timescale 1ns/100ps

// ****************************************
// small elastic fifo in the sample path
// ****************************************
module sample_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t s_q, s_d;
  logic push, pop;

  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ****************************************
// buffer control top
// ****************************************
module accel_sample_buffer_control (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire sample_buffer_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // incoming samples
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [sample_buffer_pkg::SAMPLE_W-1:0] sample_data,
  // trigger events, one-cycle pulses
  input wire logic evt_within_window,
  input wire logic evt_outside_window,
  input wire logic evt_orientation,
  // power and sensor state
  input wire sample_buffer_pkg::power_t power,
  // host control
  input wire logic [5:0] watermark_level,
  input wire logic flush_req,
  input wire logic read_req,
  // read-out and status
  output sample_buffer_pkg::sample_out_t read_out,
  output logic [sample_buffer_pkg::CNT_W-1:0] stored_count,
  output logic overflow_flag,
  output logic gate_error,
  output logic [7:0] gate_drop_count
);
  import sample_buffer_pkg::*;

  typedef struct packed {
    cfg_t cfg;
    logic [DEPTH-1:0][SAMPLE_W-1:0] mem;
    logic [PTR_W-1:0] head;
    logic [CNT_W-1:0] count;
    logic triggered;
    logic [CNT_W-1:0] post_left;
    logic ovf;
    logic gated;
    logic gate_err;
    logic [7:0] drops;
    logic sleeping_prev;
    logic run_prev;
    sample_out_t rd;
  } state_t;
  state_t s_q, s_d;

  logic f_valid, f_ready;
  logic [SAMPLE_W-1:0] f_data;
  logic cfg_locked, gate_used, rate_change, run_start, trig_hit, flush;
  logic accept_ok, take, read_pop;
  logic [PTR_W-1:0] tail, wr_idx;
  logic [CNT_W-1:0] wm;

  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ****************************************
  // derived conditions
  // ****************************************
  assign cfg_locked = power.active || power.second_pin_function;
  assign gate_used = s_q.cfg.gate &&
      !(s_q.cfg.mode == MODE_TRIGGER && power.sleep_delay_count != 8'h00);
  assign rate_change = power.sleeping != s_q.sleeping_prev;
  assign run_start = (power.active || power.external_trigger_mode) && !s_q.run_prev;
  assign trig_hit = (evt_within_window && s_q.cfg.trig_within_window_en) ||
      (evt_outside_window && s_q.cfg.trig_outside_window_en) ||
      (evt_orientation && s_q.cfg.trig_orientation_en);
  assign flush = flush_req || run_start || (rate_change && !gate_used) ||
      (s_q.cfg.mode == MODE_OFF);
  assign wm = (watermark_level > FULL_COUNT) ? FULL_COUNT : watermark_level;
  assign tail = s_q.head + PTR_W'(s_q.count - 1'b1);
  assign read_pop = read_req && (s_q.count != '0) && !flush;
  // a pop holds the fifo head back so no sample is lost; a flush drops it
  assign f_ready = !read_pop;
  assign take = f_valid && !flush && !read_pop;

  always_comb begin
    accept_ok = 1'b0;
    unique case (s_q.cfg.mode)
      MODE_OFF: accept_ok = 1'b0;
      MODE_STREAM: accept_ok = 1'b1;
      MODE_STOP: accept_ok = (s_q.count != FULL_COUNT);
      MODE_TRIGGER: accept_ok = !s_q.triggered || (s_q.post_left != '0);
    endcase
  end

  assign wr_idx = s_q.head + PTR_W'(s_q.count);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.sleeping_prev = power.sleeping;
    s_d.run_prev = power.active || power.external_trigger_mode;
    s_d.rd.valid = 1'b0;
    if (reg_req.wr && reg_req.addr == CFG_ADDR && !cfg_locked) begin
      s_d.cfg = cfg_t'(reg_req.wdata);
    end
    if (rate_change && gate_used && s_q.count != '0) begin
      s_d.gated = 1'b1;
    end
    if (s_q.cfg.mode == MODE_TRIGGER && !s_q.triggered && trig_hit) begin
      s_d.triggered = 1'b1;
      s_d.post_left = FULL_COUNT - wm;
    end
    if (flush) begin
      s_d.count = '0;
      s_d.head = '0;
      s_d.ovf = 1'b0;
      s_d.triggered = 1'b0;
      s_d.gated = 1'b0;
      s_d.gate_err = 1'b0;
      s_d.drops = '0;
    end else if (read_pop) begin
      s_d.rd.valid = 1'b1;
      if (s_q.cfg.read_order) begin
        s_d.rd.data = s_q.mem[tail];
      end else begin
        s_d.rd.data = s_q.mem[s_q.head];
        s_d.head = s_q.head + 1'b1;
      end
      s_d.count = s_q.count - 1'b1;
      if (s_q.count == CNT_W'(1)) begin
        s_d.ovf = 1'b0;
        s_d.triggered = 1'b0;
        s_d.gated = 1'b0;
        s_d.gate_err = 1'b0;
        s_d.drops = '0;
      end
    end else if (take) begin
      if (s_q.gated || (rate_change && gate_used && s_q.count != '0)) begin
        s_d.gate_err = 1'b1;
        if (s_q.drops != 8'hFF) begin
          s_d.drops = s_q.drops + 1'b1;
        end
      end else if (accept_ok) begin
        s_d.mem[wr_idx] = f_data;
        if (s_q.cfg.mode == MODE_TRIGGER && !s_q.triggered) begin
          if (s_q.count >= wm) begin
            s_d.head = s_q.head + 1'b1;
          end else begin
            s_d.count = s_q.count + 1'b1;
          end
        end else if (s_q.count == FULL_COUNT) begin
          s_d.head = s_q.head + 1'b1;
        end else begin
          s_d.count = s_q.count + 1'b1;
        end
        if (s_q.triggered) begin
          s_d.post_left = s_q.post_left - 1'b1;
          if (s_q.post_left == CNT_W'(1)) begin
            s_d.ovf = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = (reg_req.addr == CFG_ADDR) ? s_q.cfg : 8'h00;
  assign read_out = s_q.rd;
  assign stored_count = s_q.count;
  assign overflow_flag = s_q.ovf;
  assign gate_error = s_q.gate_err;
  assign gate_drop_count = s_q.drops;
endmodule

// ==== test/sample_buffer_asserts.sv ====
// checker on the sample buffer control ports
// assumes one clock and an async active-high reset
`timescale 1ns/100ps
module sample_buffer_asserts
  import sample_buffer_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register and host side
  input wire sample_buffer_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic read_req,
  input wire logic flush_req,
  input wire sample_buffer_pkg::power_t power,
  // buffer state
  input wire sample_buffer_pkg::sample_out_t read_out,
  input wire logic [sample_buffer_pkg::CNT_W-1:0] stored_count,
  input wire logic overflow_flag,
  input wire logic gate_error,
  input wire logic [7:0] gate_drop_count
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ****
  // sequences
  // ****
  sequence s_quiet;
    !flush_req && !reg_req.wr && !$past(reg_req.wr) && $stable(power);
  endsequence
  sequence s_pop;
    read_req && stored_count != 6'h00 ##0 s_quiet;
  endsequence
  sequence s_idle;
    !read_req ##0 s_quiet;
  endsequence
  a_pop_answer: assert property (s_pop |=> read_out.valid &&
    stored_count == $past(stored_count) - 1) else $error("read not answered");
  a_flush_clear: assert property (flush_req |=> stored_count == 6'h00 &&
    !overflow_flag && !gate_error && gate_drop_count == 8'h00) else $error("flush incomplete");
  a_count_bound: assert property (stored_count <= FULL_COUNT &&
    stored_count <= $past(stored_count) + 1) else $error("count jumped");
  a_drops_err: assert property (gate_drop_count != 8'h00 |-> gate_error)
    else $error("drops without error");
  a_err_hold: assert property (gate_error && stored_count != 6'h00 ##0 s_idle |=> gate_error)
    else $error("gate error dropped");
  a_cfg_lock: assert property (reg_req.wr && reg_req.addr == CFG_ADDR &&
    (power.active || power.second_pin_function)
    |=> reg_req.addr != CFG_ADDR || reg_rdata == $past(reg_rdata)) else $error("locked write");
  a_off_empty: assert property ((reg_req.addr == CFG_ADDR && reg_rdata[6:5] == 2'b00) [*2]
    |-> stored_count == 6'h00) else $error("mode off holds data");
  a_ovf_stop: assert property (overflow_flag ##0 s_idle |=> $stable(stored_count))
    else $error("stored after overflow");
endmodule
bind accel_sample_buffer_control sample_buffer_asserts chk (.clk_sys, .sys_rst, .reg_req,
  .reg_rdata, .read_req, .flush_req, .power, .read_out, .stored_count, .overflow_flag,
  .gate_error, .gate_drop_count);

// ==== test/host_reader.sv ====
// host model that drains or flushes the sample buffer
// assumes the bench sets drain, slow and flush_cmd off the edge
`timescale 1ns/100ps
module host_reader
  import sample_buffer_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // bench commands
  input wire logic drain,
  input wire logic slow,
  input wire logic flush_cmd,
  // buffer side
  input wire logic [sample_buffer_pkg::CNT_W-1:0] stored_count,
  input wire sample_buffer_pkg::sample_out_t read_out,
  output logic read_req = 1'b0,
  output logic flush_req = 1'b0
);
  logic [SAMPLE_W-1:0] got[$];
  always @(posedge clk_sys) begin
    if (read_out.valid)
      got.push_back(read_out.data);
    flush_req <= flush_cmd && !sys_rst;
    // one pop in flight at a time, slow mode leaves random gaps
    read_req <= drain && !sys_rst && !read_req && stored_count != 6'h00
      && (!slow || $urandom_range(1) == 0);
  end
endmodule

// ==== test/tb_accel_sample_buffer_control.sv ====
// self-checking bench for the sample buffer control block
// assumes host_reader and the bound checker are compiled first
`timescale 1ns/100ps
module tb_accel_sample_buffer_control;
  import sample_buffer_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t reg_req = '{addr: CFG_ADDR, wdata: 8'h00, wr: 1'b0};
  power_t power = '0;
  logic sample_valid = 1'b0;
  logic [SAMPLE_W-1:0] sample_data = '0;
  logic [2:0] evt = 3'h0;
  logic [5:0] watermark_level = 6'h00;
  logic drain = 1'b0, slow = 1'b0, flush_cmd = 1'b0;
  logic [7:0] reg_rdata, gate_drop_count;
  logic sample_ready, read_req, flush_req, overflow_flag, gate_error;
  sample_out_t read_out;
  logic [CNT_W-1:0] stored_count;
  logic [SAMPLE_W-1:0] sent[$];
  int miscompares = 0, tests_run = 0;
  always #4 clk_sys = ~clk_sys;
  accel_sample_buffer_control uut (.clk_sys, .sys_rst, .reg_req, .reg_rdata, .sample_valid,
    .sample_ready, .sample_data, .evt_within_window(evt[2]), .evt_outside_window(evt[1]),
    .evt_orientation(evt[0]), .power, .watermark_level, .flush_req, .read_req, .read_out,
    .stored_count, .overflow_flag, .gate_error, .gate_drop_count);
  host_reader host (.clk_sys, .sys_rst, .drain, .slow, .flush_cmd, .stored_count, .read_out,
    .read_req, .flush_req);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wcfg(input logic [7:0] v);
    reg_req.wdata = v;
    reg_req.wr = 1'b1;
    tick(1);
    reg_req.wr = 1'b0;
    tick(1);
  endtask
  task automatic push(input int n);
    sample_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      sample_data = {$urandom, 4'(i)};
      while (sample_ready !== 1'b1) tick(1);
      sent.push_back(sample_data);
      tick(1);
    end
    sample_valid = 1'b0;
    tick(12);
  endtask
  function automatic int pick(input int k, input int first, input int n, input bit lifo);
    return lifo ? first + n - 1 - k : first + k;
  endfunction
  task automatic drain_check(input int first, input int n, input bit lifo);
    host.got.delete();
    drain = 1'b1;
    slow = 1'($urandom_range(1));
    for (int k = 0; k < 400 && stored_count != 6'h00; k++) tick(1);
    tick(4);
    drain = 1'b0;
    chk(host.got.size(), n);
    for (int k = 0; k < n; k++) chk(host.got[k], sent[pick(k, first, n, lifo)]);
  endtask
  task automatic next(input string s);
    $display("test %s done", s);
    wcfg(8'h00);
    sent.delete();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(30000);
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h0C94E076));
    tick(2);
    sys_rst = 1'b0;
    chk(reg_rdata, CFG_RESET);
    chk(sample_ready, 1'b1);
    reg_req.addr = 8'h27;
    tick(1);
    chk(reg_rdata, 8'h00);
    reg_req.addr = CFG_ADDR;
    push(3);
    chk(stored_count, 6'h00);
    next("off");
    wcfg(8'h20);
    push(40);
    chk(stored_count, FULL_COUNT);
    drain_check(8, 32, 1'b0);
    next("stream");
    wcfg(8'hC0);
    push(40);
    chk(stored_count, FULL_COUNT);
    drain_check(0, 32, 1'b1);
    next("stop");
    for (int s = 0; s < 3; s++) begin
      watermark_level = 6'($urandom_range(31, 1));
      wcfg(8'h60 | 8'(s == 2 ? 8 : s == 1 ? 4 : 1));
      push(watermark_level + 5);
      evt = 3'h7 ^ 3'(1 << s);
      tick(1);
      evt = 3'h0;
      push(1);
      chk(stored_count, watermark_level);
      evt = 3'(1 << s);
      tick(1);
      evt = 3'h0;
      push(40);
      chk({overflow_flag, stored_count}, {1'b1, FULL_COUNT});
      drain_check(6, 32, 1'b0);
      chk(overflow_flag, 1'b0);
      next("trigger");
    end
    wcfg(8'h30);
    push(5);
    power.sleeping = 1'b1;
    push(3);
    chk({gate_error, gate_drop_count, stored_count}, {1'b1, 8'h03, 6'h05});
    flush_cmd = 1'b1;
    tick(1);
    flush_cmd = 1'b0;
    tick(2);
    chk({gate_error, stored_count}, 7'h00);
    push(2);
    chk(stored_count, 6'h02);
    next("gate");
    wcfg(8'h20);
    push(4);
    power.sleeping = 1'b0;
    tick(2);
    chk(stored_count, 6'h00);
    push(4);
    power.active = 1'b1;
    tick(2);
    chk(stored_count, 6'h00);
    wcfg(8'h00);
    chk(reg_rdata, 8'h20);
    power.active = 1'b0;
    next("power");
    wcfg(8'h70);
    watermark_level = 6'h08;
    power.sleep_delay_count = 8'h01;
    push(4);
    power.sleeping = 1'b1;
    tick(2);
    chk({gate_error, stored_count}, 7'h00);
    push(3);
    power.second_pin_function = 1'b1;
    wcfg(8'h20);
    chk(reg_rdata, 8'h70);
    power.external_trigger_mode = 1'b1;
    tick(2);
    chk(stored_count, 6'h00);
    power = '0;
    next("sleep delay");
    report_and_stop();
  end
endmodule
